// file: rtl/tbam_pkg.sv
// constants and types for the ten-bit multi-address target matcher
package tbam_pkg;

  localparam int ADDR_W = 10;
  localparam int NADDR_DEF = 4;
  localparam int NADDR_MAX = 4;
  localparam logic [4:0] PREFIX_10B = 5'h1e;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] HI_RST = 2'h0;
  localparam int CFG_WAIT_MAX = 40;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_DATA,
    ST_IGNORE
  } tbam_state_t;

endpackage : tbam_pkg

// file: rtl/tbam_match.sv
// ten-bit multi-address target matcher with link-side bit engine
`timescale 1ns/1ps
`default_nettype none

module tbam_match
  import tbam_pkg::*;
#(
  parameter int NADDR = NADDR_DEF
) (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // link clock
  input wire logic link_clk_i,
  // own address table, entry i in bits [i*10+9:i*10]
  input wire logic [NADDR*ADDR_W-1:0] own_addr_i,
  input wire logic [NADDR-1:0] addr_en_i,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // core-side results
  output logic cfg_busy_o,
  output logic match_o,
  output logic [1:0] match_idx_o,
  output logic data_valid_o,
  output logic [7:0] data_o
);

  localparam int CFG_W = NADDR * (ADDR_W + 1);
  // bound of the table transfer check, held locally so the property range is plain
  localparam int CFG_WAIT_LIM = CFG_WAIT_MAX;

  // the index output and table layout only serve up to four entries
  if (NADDR < 1 || NADDR > NADDR_MAX) begin : g_bad_naddr
    $error("tbam_match: NADDR must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release, one synchroniser per domain
  logic crst_s1, crst_n;
  logic lrst_s1, lrst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crst_s1 <= 1'b0;
      crst_n <= 1'b0;
    end else begin
      crst_s1 <= 1'b1;
      crst_n <= crst_s1;
    end
  end

  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lrst_s1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n <= lrst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core side: table capture and request toggle
  logic [CFG_W-1:0] cfg_hold;
  logic cfg_req, ack_s1, ack_s2, link_ack;

  // hold stays frozen while pending, so the link may load it as a word
  always_ff @(posedge core_clk_i or negedge crst_n) begin
    if (!crst_n) begin
      cfg_hold <= '0;
      cfg_req <= 1'b0;
      cfg_busy_o <= 1'b0;
    end else if (cfg_busy_o) begin
      if (ack_s2 == cfg_req) begin
        cfg_busy_o <= 1'b0;
      end
    end else if ({addr_en_i, own_addr_i} != cfg_hold) begin
      cfg_hold <= {addr_en_i, own_addr_i};
      cfg_req <= ~cfg_req;
      cfg_busy_o <= 1'b1;
    end
  end

  // acknowledge toggle back from the link
  always_ff @(posedge core_clk_i or negedge crst_n) begin
    if (!crst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= link_ack;
      ack_s2 <= ack_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: table shadow
  logic req_s1, req_s2, req_q;
  logic [ADDR_W-1:0] tab [NADDR];
  logic [NADDR-1:0] tab_en;

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_q <= 1'b0;
      link_ack <= 1'b0;
    end else begin
      req_s1 <= cfg_req;
      req_s2 <= req_s1;
      req_q <= req_s2;
      link_ack <= req_s2;
    end
  end

  // table loads on the request edge; changes mid-frame take effect at once
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      tab_en <= '0;
    end else if (req_s2 != req_q) begin
      tab_en <= cfg_hold[CFG_W-1 -: NADDR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detection
  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  assign start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign stop_det = scl_s2 & scl_q & ~sda_q & sda_s2;

  ////////////////////////////////////////////////////////////////////////////
  // bit engine: eight data bits then the acknowledge bit
  tbam_state_t st;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic [1:0] hi2;
  logic rx_on, byte_end, ack_end;

  assign rx_on = (st == ST_ADDR_HI) || (st == ST_ADDR_LO) || (st == ST_DATA);
  assign byte_end = rx_on & scl_fall & (cnt == BIT_LAST) & ~start_det & ~stop_det;
  assign ack_end = scl_fall & (cnt == BIT_ACK) & ~start_det & ~stop_det;

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      sh <= BYTE_RST;
      cnt <= CNT_RST;
    end else if (start_det || stop_det || !rx_on) begin
      cnt <= CNT_RST;
    end else if (scl_rise && cnt < BIT_LAST) begin
      sh <= {sh[6:0], sda_s2};
      cnt <= cnt + 4'h1;
    end else if (byte_end) begin
      cnt <= BIT_ACK;
    end else if (ack_end) begin
      cnt <= CNT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address compare, one entry per generate pass
  logic [NADDR-1:0] hi_hit, full_hit;
  logic hi_ok, lo_ok;
  logic [1:0] hit_idx;

  for (genvar i = 0; i < NADDR; i++) begin : g_cmp
    always_ff @(posedge link_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
        tab[i] <= '0;
      end else if (req_s2 != req_q) begin
        tab[i] <= cfg_hold[i*ADDR_W +: ADDR_W];
      end
    end
    assign hi_hit[i] = tab_en[i] & (tab[i][9:8] == sh[2:1]);
    assign full_hit[i] = tab_en[i] & (tab[i] == {hi2, sh});
  end

  assign hi_ok = (sh[7:3] == PREFIX_10B) & ~sh[0] & (|hi_hit);
  assign lo_ok = |full_hit;

  // lowest matching entry wins when software loads duplicates
  always_comb begin
    hit_idx = 2'h0;
    for (int k = NADDR - 1; k >= 0; k--) begin
      if (full_hit[k]) begin
        hit_idx = k[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame state: a start always reopens address phase, a stop idles
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      st <= ST_IDLE;
      hi2 <= HI_RST;
    end else if (start_det) begin
      st <= ST_ADDR_HI;
    end else if (stop_det) begin
      st <= ST_IDLE;
    end else if (byte_end) begin
      case (st)
        ST_ADDR_HI: begin
          hi2 <= sh[2:1];
          st <= hi_ok ? ST_ADDR_LO : ST_IGNORE;
        end
        ST_ADDR_LO: st <= lo_ok ? ST_DATA : ST_IGNORE;
        ST_DATA: st <= ST_DATA;
        default: st <= ST_IGNORE;
      endcase
    end
  end

  // acknowledge drive: pull low through the ninth bit on an address hit and on every data byte
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (start_det || stop_det || ack_end) begin
      sda_oe_o <= 1'b0;
    end else if (byte_end) begin
      sda_oe_o <= (st == ST_ADDR_HI) ? hi_ok : (st == ST_ADDR_LO) ? lo_ok : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events to the core, toggle plus a word stable for a whole byte time
  logic evt_tgl, evt_kind;
  logic [1:0] evt_idx;
  logic [7:0] evt_byte;

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      evt_tgl <= 1'b0;
      evt_kind <= 1'b0;
      evt_idx <= 2'h0;
      evt_byte <= BYTE_RST;
    end else if (byte_end && st == ST_ADDR_LO && lo_ok) begin
      evt_tgl <= ~evt_tgl;
      evt_kind <= 1'b1;
      evt_idx <= hit_idx;
    end else if (byte_end && st == ST_DATA) begin
      evt_tgl <= ~evt_tgl;
      evt_kind <= 1'b0;
      evt_byte <= sh;
    end
  end

  logic ev_s1, ev_s2, ev_q;

  always_ff @(posedge core_clk_i or negedge crst_n) begin
    if (!crst_n) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_q <= 1'b0;
    end else begin
      ev_s1 <= evt_tgl;
      ev_s2 <= ev_s1;
      ev_q <= ev_s2;
    end
  end

  // one-cycle result pulses in the core domain
  always_ff @(posedge core_clk_i or negedge crst_n) begin
    if (!crst_n) begin
      match_o <= 1'b0;
      match_idx_o <= 2'h0;
      data_valid_o <= 1'b0;
      data_o <= BYTE_RST;
    end else begin
      match_o <= (ev_s2 != ev_q) & evt_kind;
      data_valid_o <= (ev_s2 != ev_q) & ~evt_kind;
      if (ev_s2 != ev_q && evt_kind) begin
        match_idx_o <= evt_idx;
      end
      if (ev_s2 != ev_q && !evt_kind) begin
        data_o <= evt_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_hi_end;
    byte_end && st == ST_ADDR_HI;
  endsequence

  sequence s_lo_end;
    byte_end && st == ST_ADDR_LO;
  endsequence

  a_hi_ack_hit: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    s_hi_end and hi_ok |=> sda_oe_o && st == ST_ADDR_LO)
    else $error("first address byte hit not acknowledged");

  a_hi_bad_prefix: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    s_hi_end and (sh[7:3] != PREFIX_10B) |=> !sda_oe_o && st == ST_IGNORE)
    else $error("byte without ten-bit prefix acknowledged");

  a_lo_full_only: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    (sda_oe_o && !$past(sda_oe_o) && $past(st) == ST_ADDR_LO) |-> $past(lo_ok))
    else $error("second byte acknowledged without full match");

  a_lo_nack_idle: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    s_lo_end and !lo_ok |=> (!sda_oe_o && st == ST_IGNORE) [*2])
    else $error("unmatched second byte not left released");

  a_ignore_quiet: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    st == ST_IGNORE |-> !sda_oe_o)
    else $error("bus driven while ignoring");

  a_data_after_match: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    (st == ST_DATA && $past(st) != ST_DATA) |-> ($past(st) == ST_ADDR_LO && $past(lo_ok)))
    else $error("data phase entered without full match");

  a_ack_release: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    (sda_oe_o && ack_end) |=> !sda_oe_o)
    else $error("acknowledge held past ninth bit");

  a_data_pulse: assert property (@(posedge core_clk_i) disable iff (!crst_n)
    data_valid_o |=> !data_valid_o && !match_o)
    else $error("data pulse longer than one cycle");

  a_table_load: assert property (@(posedge core_clk_i) disable iff (!crst_n)
    $rose(cfg_busy_o) |-> ##[1:CFG_WAIT_LIM] !cfg_busy_o)
    else $error("address table transfer did not complete");

endmodule : tbam_match

`default_nettype wire

// file: tb/tbam_master.sv
// two-wire bus master model issuing ten-bit addressed frames
`timescale 1ns/1ps
`default_nettype none

module tbam_master #(
  parameter int Q = 16
) (
  // clock
  input wire logic clk_i,
  // target pin drive
  input wire logic dut_sda_i,
  input wire logic dut_oe_i,
  // bus wires
  output logic scl_o,
  output logic sda_o
);
  logic drv_low;

  // bus idles high; scl stands still between frames
  initial begin
    scl_o = 1'b1;
    drv_low = 1'b0;
  end

  // open drain with pull-up: a released line reads high
  assign sda_o = drv_low ? 1'b0 : (dut_oe_i ? dut_sda_i : 1'b1);

  ////////////////////////////////////////
  task automatic wq(input int n);
    repeat (n * Q) @(posedge clk_i);
  endtask : wq

  // start, also used as repeated start from scl low
  task automatic start_c;
    drv_low <= 1'b0;
    wq(1);
    scl_o <= 1'b1;
    wq(1);
    drv_low <= 1'b1;
    wq(1);
    scl_o <= 1'b0;
    wq(1);
  endtask : start_c

  // eight bits msb first, then release for the ninth bit
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv_low <= ~b[i];
      wq(1);
      scl_o <= 1'b1;
      wq(2);
      scl_o <= 1'b0;
      wq(1);
    end
    drv_low <= 1'b0;
    wq(1);
    scl_o <= 1'b1;
    wq(1);
    ack = ~sda_o;
    wq(1);
    scl_o <= 1'b0;
    wq(1);
  endtask : xfer

  task automatic stop_c;
    drv_low <= 1'b1;
    wq(1);
    scl_o <= 1'b1;
    wq(1);
    drv_low <= 1'b0;
    wq(2);
  endtask : stop_c
endmodule : tbam_master

`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the ten-bit multi-address matcher
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import tbam_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4*ADDR_W-1:0] own = {10'h30c, 10'h0f0, 10'h2aa, 10'h155};
  logic [3:0] en = 4'hf;
  wire logic scl, sda, sda_o, sda_oe, busy, match, dv;
  wire logic [1:0] idx;
  wire logic [7:0] dat;
  logic [1:0] last_idx;
  logic [7:0] last_data;
  int n_mismatch = 0;
  int compares = 0;
  int n_match = 0;
  int n_data = 0;

  // clocks of unrelated phase
  always #2.5 core_clk = ~core_clk;
  always #6 link_clk = ~link_clk;

  tbam_match #(.NADDR(4)) dut (.core_clk_i(core_clk), .arst_n_i(arst_n), .link_clk_i(link_clk),
    .own_addr_i(own), .addr_en_i(en), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .cfg_busy_o(busy), .match_o(match), .match_idx_o(idx), .data_valid_o(dv), .data_o(dat));
  tbam_master m (.clk_i(core_clk), .dut_sda_i(sda_o), .dut_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  // pulses last one cycle, so every edge is watched
  always @(posedge core_clk) begin
    if (match === 1'b1) begin
      n_match <= n_match + 1;
      last_idx <= idx;
    end
    if (dv === 1'b1) begin
      n_data <= n_data + 1;
      last_data <= dat;
    end
  end

  ////////////////////////////////////////
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic complete_run;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // bounded wait for the table transfer
  task automatic wait_cfg;
    for (int i = 0; i < CFG_WAIT_MAX; i++) begin
      @(posedge core_clk);
      if (busy === 1'b0)
        return;
    end
    n_mismatch++;
    complete_run();
  endtask : wait_cfg

  task automatic addr10(input logic [1:0] hi, input logic [7:0] lo, output logic a1, output logic a2);
    m.start_c();
    m.xfer({PREFIX_10B, hi, 1'b0}, a1);
    m.xfer(lo, a2);
  endtask : addr10

  ////////////////////////////////////////
  // every entry, each with its own top bits
  task automatic t_full;
    logic a1, a2, a3;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 8'h81 + 8'(i);
      addr10(own[i*10+8 +: 2], own[i*10 +: 8], a1, a2);
      m.xfer(d, a3);
      m.stop_c();
      chk1(a1, 1'b1);
      chk1(a2, 1'b1);
      chk1(a3, 1'b1);
      chk8(8'(n_match), 8'(i + 1));
      chk8({6'h00, last_idx}, 8'(i));
      chk8(last_data, d);
    end
  endtask : t_full

  // top bits of one entry, low bits of another
  task automatic t_mixed;
    logic a1, a2, a3;
    addr10(2'h1, 8'haa, a1, a2);
    m.xfer(8'h5a, a3);
    chk1(a1, 1'b1);
    chk1(a2, 1'b0);
    chk1(a3, 1'b0);
    addr10(2'h2, 8'haa, a1, a2);
    m.stop_c();
    chk1(a2, 1'b1);
    chk8(8'(n_data), 8'h04);
    chk8(8'(n_match), 8'h05);
    chk8({6'h00, last_idx}, 8'h01);
  endtask : t_mixed

  // bad prefix, read direction, disabled entry
  task automatic t_first;
    logic a1, a2;
    m.start_c();
    m.xfer(8'he2, a1);
    chk1(a1, 1'b0);
    m.start_c();
    m.xfer({PREFIX_10B, 2'h1, 1'b1}, a1);
    chk1(a1, 1'b0);
    m.stop_c();
    @(posedge core_clk);
    en <= 4'h7;
    repeat (2) @(posedge core_clk);
    wait_cfg();
    addr10(2'h3, 8'h0c, a1, a2);
    m.stop_c();
    chk1(a1, 1'b0);
    chk1(a2, 1'b0);
    chk8(8'(n_match), 8'h05);
  endtask : t_first

  // shared top bits in every entry, with a duplicate to show lowest index wins
  task automatic t_same;
    logic a1, a2, a3;
    @(posedge core_clk);
    own <= {10'h1aa, 10'h1c3, 10'h1aa, 10'h155};
    en <= 4'hf;
    repeat (2) @(posedge core_clk);
    wait_cfg();
    addr10(2'h1, 8'hc3, a1, a2);
    m.xfer(8'h3c, a3);
    m.stop_c();
    chk1(a1, 1'b1);
    chk1(a2, 1'b1);
    chk1(a3, 1'b1);
    chk8({6'h00, last_idx}, 8'h02);
    chk8(last_data, 8'h3c);
    addr10(2'h1, 8'haa, a1, a2);
    m.stop_c();
    chk1(a2, 1'b1);
    chk8({6'h00, last_idx}, 8'h01);
    addr10(2'h1, 8'h0f, a1, a2);
    m.xfer(8'h77, a3);
    m.stop_c();
    chk1(a1, 1'b1);
    chk1(a2, 1'b0);
    chk1(a3, 1'b0);
    chk8(8'(n_match), 8'h07);
    chk8(8'(n_data), 8'h05);
  endtask : t_same

  // reset, table load, then the scenarios
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    wait_cfg();
    t_full();
    t_mixed();
    t_first();
    t_same();
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
